// File: pkg/lsf_pkg.sv
// Purpose: constants and carriers for the lin/uart status and flag bank
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   control register included so the command decode has a source
package lsf_pkg;
  localparam logic [7:0] CTRL_OFF   = 8'hc8;
  localparam logic [7:0] STAT_OFF   = 8'hc9;
  localparam logic [7:0] IEN_OFF    = 8'hca;
  localparam logic [7:0] ERR_OFF    = 8'hcb;
  localparam logic [7:0] DATA_OFF   = 8'hd2;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] STAT_RST   = 8'h00;
  localparam logic [7:0] IEN_RST    = 8'h00;
  localparam logic [7:0] ERR_RST    = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;
  // control register fields
  localparam int CTRL_ENA_BIT  = 3;
  localparam int CTRL_UART_BIT = 2;
  // status register fields
  localparam int ST_IDST_LSB   = 5;
  localparam int ST_BUSY_BIT   = 4;
  localparam int ST_ERR_BIT    = 3;
  localparam int ST_ID_BIT     = 2;
  localparam int ST_TX_BIT     = 1;
  localparam int ST_RX_BIT     = 0;
  // enable register fields
  localparam int EN_ERR_BIT    = 3;
  localparam int EN_ID_BIT     = 2;
  localparam int EN_TX_BIT     = 1;
  localparam int EN_RX_BIT     = 0;
  localparam logic [7:0] IEN_MASK = 8'h0f;
  // error register bit positions
  localparam int ER_ABORT = 7;
  localparam int ER_TOUT  = 6;
  localparam int ER_OVR   = 5;
  localparam int ER_FRM   = 4;
  localparam int ER_SYNC  = 3;
  localparam int ER_PAR   = 2;
  localparam int ER_CSUM  = 1;
  localparam int ER_BIT   = 0;
  // special identifiers
  localparam logic [5:0] ID_60 = 6'h3c;

  typedef enum logic [2:0] {
    LSF_CMD_RX_HDR  = 3'b000,
    LSF_CMD_TX_HDR  = 3'b001,
    LSF_CMD_RX_RSP  = 3'b010,
    LSF_CMD_TX_RSP  = 3'b011,
    LSF_CMD_UART_OFF = 3'b100
  } lsf_cmd_e;

  typedef struct packed {
    logic       abort;
    logic       timeout;
    logic       overrun;
    logic       framing;
    logic       sync;
    logic       parity;
    logic       checksum;
    logic       bit_err;
  } lsf_err_s;

  typedef struct packed {
    logic       id_rcvd;
    logic       hdr_tx_done;
    logic       rsp_tx_done;
    logic       rsp_rx_done;
    logic       busy;
    logic [5:0] ident;
  } lsf_evt_s;

  typedef struct packed {
    logic rx_header;
    logic tx_header;
    logic rx_response;
    logic tx_response;
    logic uart_off;
    logic uart_rx_en;
    logic uart_tx_en;
  } lsf_cmd_s;
endpackage

// File: hw/lsf_flags.sv
// Purpose: status, interrupt enable and error flag bank of a lin/uart controller
// Assumes: event inputs are one-cycle pulses from the frame engine except busy, a level, synchronous
// Notes:   reads return data one cycle after the read strobe
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module lsf_flags
  import lsf_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire lsf_evt_s   evt_i,
  input  wire lsf_err_s   err_i,
  output lsf_cmd_s        cmd_o,
  output logic            irq_err_o,
  output logic            irq_ok_o
);

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [2:0] flag_reg;   // id, tx, rx
  logic [2:0] flag_next;
  logic [7:0] ien_reg;
  logic [7:0] ien_next;
  logic [7:0] err_reg;
  logic [7:0] err_next;
  logic [2:0] idst_reg;
  logic [2:0] idst_next;
  logic       busy_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  lsf_cmd_s   cmd_reg;
  lsf_cmd_s   cmd_next;
  logic       irq_err_reg;
  logic       irq_ok_reg;

  // decode
  wire        sel_ctrl   = addr_i == CTRL_OFF;
  wire        sel_stat   = addr_i == STAT_OFF;
  wire        sel_ien    = addr_i == IEN_OFF;
  wire        sel_err    = addr_i == ERR_OFF;
  wire        sel_data   = addr_i == DATA_OFF;
  wire        uart_mode  = ctrl_reg[CTRL_UART_BIT];
  wire        ctl_ena    = ctrl_reg[CTRL_ENA_BIT];
  wire [2:0]  code       = ctrl_reg[2:0];
  wire        err_sum    = |err_reg;

  wire        wr_stat    = wr_i && sel_stat;
  // summary clear: write-one or uart data read
  wire        err_clr    = (wr_stat && wdata_i[ST_ERR_BIT])
                         || (rd_i && sel_data && uart_mode);
  wire        dat_wr_clr = wr_i && sel_data && uart_mode;
  wire [2:0]  flag_w1c   = wr_stat ? wdata_i[2:0] : 3'h0;
  wire [2:0]  flag_clr   = flag_w1c | {1'b0, dat_wr_clr, dat_wr_clr};

  // abort recorded when an enabled controller in lin mode is switched to rx header
  wire        abort_cmd  = wr_i && sel_ctrl && wdata_i[CTRL_ENA_BIT]
                         && !wdata_i[CTRL_UART_BIT] && wdata_i[2:0] == 3'h0
                         && ctl_ena && !uart_mode;

  wire [7:0]  err_set    = {err_i.abort | abort_cmd, err_i.timeout, err_i.overrun,
                            err_i.framing, err_i.sync, err_i.parity,
                            err_i.checksum, err_i.bit_err};
  // set beats clear so a same-cycle event is kept
  assign err_next  = err_set | (err_clr ? 8'h00 : err_reg);

  wire [2:0]  flag_set   = {evt_i.id_rcvd | evt_i.hdr_tx_done,
                            evt_i.rsp_tx_done, evt_i.rsp_rx_done};
  assign flag_next = flag_set | (flag_reg & ~flag_clr);

  function automatic logic [2:0] id_status(input logic [5:0] id);
    id_status = (id[5:2] == ID_60[5:2]) ? {1'b1, id[1:0]} : 3'b000;
  endfunction

  assign idst_next = (evt_i.id_rcvd | evt_i.hdr_tx_done) ? id_status(evt_i.ident)
                   : idst_reg;

  assign ctrl_next = (wr_i && sel_ctrl) ? wdata_i : ctrl_reg;
  assign ien_next  = (wr_i && sel_ien) ? (wdata_i & IEN_MASK) : ien_reg;

  // command decode; nothing issued while disabled
  always_comb begin
    cmd_next = '0;
    if (ctl_ena) begin
      if (uart_mode) begin
        cmd_next.uart_off   = code == LSF_CMD_UART_OFF;
        cmd_next.uart_rx_en = code[2] & code[1];
        cmd_next.uart_tx_en = code[2] & code[0];
      end else begin
        case (code)
          LSF_CMD_RX_HDR: cmd_next.rx_header   = 1'b1;
          LSF_CMD_TX_HDR: cmd_next.tx_header   = 1'b1;
          LSF_CMD_RX_RSP: cmd_next.rx_response = 1'b1;
          LSF_CMD_TX_RSP: cmd_next.tx_response = 1'b1;
          default:        cmd_next = '0;
        endcase
      end
    end
  end

  wire [7:0] stat_view = {idst_reg, busy_reg, err_sum, flag_reg};

  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      case (addr_i)
        CTRL_OFF: rdata_next = ctrl_reg;
        STAT_OFF: rdata_next = stat_view;
        IEN_OFF:  rdata_next = ien_reg;
        ERR_OFF:  rdata_next = err_reg;
        default:  rdata_next = 8'h00;
      endcase
    end
  end

  // interrupt levels from next state so they track flags exactly
  wire irq_err_next = |err_next && ien_next[EN_ERR_BIT];
  wire irq_ok_next  = |(flag_next & ien_next[2:0]);

  // software-owned registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      ien_reg  <= IEN_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      ien_reg  <= ien_next;
    end
  end

  // hardware-set flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 3'h0;
      err_reg  <= ERR_RST;
    end else begin
      flag_reg <= flag_next;
      err_reg  <= err_next;
    end
  end

  // frame status mirrors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idst_reg <= 3'h0;
      busy_reg <= 1'b0;
    end else begin
      idst_reg <= idst_next;
      busy_reg <= evt_i.busy;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg   <= 8'h00;
      cmd_reg     <= '0;
      irq_err_reg <= 1'b0;
      irq_ok_reg  <= 1'b0;
    end else begin
      rdata_reg   <= rdata_next;
      cmd_reg     <= cmd_next;
      irq_err_reg <= irq_err_next;
      irq_ok_reg  <= irq_ok_next;
    end
  end

  assign rdata_o   = rdata_reg;
  assign cmd_o     = cmd_reg;
  assign irq_err_o = irq_err_reg;
  assign irq_ok_o  = irq_ok_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sum_clear;
    wr_i && sel_stat && wdata_i[ST_ERR_BIT] && !(|err_set);
  endsequence

  a_sum_clears_all: assert property (s_sum_clear |=> err_reg == 8'h00)
    else $error("error clear left bits set");
  a_uart_read_clr: assert property (rd_i && sel_data && uart_mode && !(|err_set)
                                    |=> err_reg == 8'h00)
    else $error("uart data read did not clear errors");
  a_uart_write_clr: assert property (wr_i && sel_data && uart_mode
                                     && !evt_i.rsp_tx_done && !evt_i.rsp_rx_done
                                     |=> flag_reg[1:0] == 2'b00)
    else $error("uart data write did not clear done flags");
  a_flag_sticky: assert property (wr_i && sel_stat && wdata_i[2:0] == 3'h0
                                  && !(wr_i && sel_data && uart_mode)
                                  |=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
    else $error("flag lost on write of zero");
  a_done_sets: assert property (evt_i.rsp_rx_done |=> flag_reg[ST_RX_BIT])
    else $error("rx done not set");
  a_err_sets: assert property (err_i.timeout |=> err_reg[ER_TOUT] && err_sum)
    else $error("time-out not flagged");
  a_irq_level: assert property (flag_reg[ST_TX_BIT] && ien_reg[EN_TX_BIT]
                                |-> irq_ok_o)
    else $error("irq dropped with enabled flag set");
  a_irq_masked: assert property (ien_reg[EN_ERR_BIT] == 1'b0 |-> !irq_err_o)
    else $error("error irq while masked");
  a_cmd_disabled: assert property (!ctl_ena |=> cmd_o == '0)
    else $error("command issued while disabled");
  a_busy_follows: assert property (evt_i.busy |=> stat_view[ST_BUSY_BIT])
    else $error("busy not shown");
  a_id_status: assert property (evt_i.id_rcvd && evt_i.ident == 6'h3e
                                |=> idst_reg == 3'b110)
    else $error("identifier status wrong");

  sequence s_id_event;
    evt_i.id_rcvd || evt_i.hdr_tx_done;
  endsequence

  // flag setting
  a_id_event_sets: assert property (s_id_event |=> flag_reg[ST_ID_BIT])
    else $error("identifier flag not set");
  a_hdr_sets_id: assert property (evt_i.hdr_tx_done |=> flag_reg[ST_ID_BIT])
    else $error("header sent did not set identifier flag");
  a_tx_done_sets: assert property (evt_i.rsp_tx_done |=> flag_reg[ST_TX_BIT])
    else $error("tx done not set");
  a_idst_holds: assert property (!evt_i.id_rcvd && !evt_i.hdr_tx_done
                                 |=> $stable(idst_reg))
    else $error("identifier status moved without event");

  // error bits
  a_abort_sets: assert property (err_i.abort |=> err_reg[ER_ABORT])
    else $error("abort not flagged");
  a_abort_cmd: assert property (wr_i && sel_ctrl && wdata_i[3:0] == 4'h8
                                && ctl_ena && !uart_mode |=> err_reg[ER_ABORT])
    else $error("abort command not flagged");
  a_ovr_sets: assert property (err_i.overrun |=> err_reg[ER_OVR])
    else $error("overrun not flagged");
  a_frm_sets: assert property (err_i.framing |=> err_reg[ER_FRM])
    else $error("framing error not flagged");
  a_sync_sets: assert property (err_i.sync |=> err_reg[ER_SYNC])
    else $error("sync error not flagged");
  a_par_sets: assert property (err_i.parity |=> err_reg[ER_PAR])
    else $error("parity error not flagged");
  a_csum_sets: assert property (err_i.checksum |=> err_reg[ER_CSUM])
    else $error("checksum error not flagged");
  a_bit_sets: assert property (err_i.bit_err |=> err_reg[ER_BIT])
    else $error("bit error not flagged");
  a_err_read_only: assert property (wr_i && sel_err && !(|err_set)
                                    |=> $stable(err_reg))
    else $error("error register changed by write");
  a_lin_read_keeps: assert property (rd_i && sel_data && !uart_mode
                                     && err_reg != 8'h00 |=> err_reg != 8'h00)
    else $error("lin data read cleared errors");

  // read view
  a_sum_read: assert property (rd_i && sel_stat
                               |=> rdata_o[ST_ERR_BIT] == (|$past(err_reg)))
    else $error("error summary read wrong");
  a_busy_read: assert property (rd_i && sel_stat
                                |=> rdata_o[ST_BUSY_BIT] == $past(busy_reg))
    else $error("busy read wrong");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");

  // write-one clears
  a_id_w1c: assert property (wr_i && sel_stat && wdata_i[ST_ID_BIT]
                             && !evt_i.id_rcvd && !evt_i.hdr_tx_done
                             |=> !flag_reg[ST_ID_BIT])
    else $error("identifier flag not cleared");
  a_rx_keep_zero: assert property (wr_i && sel_stat && !wdata_i[ST_RX_BIT]
                                   && flag_reg[ST_RX_BIT] |=> flag_reg[ST_RX_BIT])
    else $error("rx flag lost on zero write");
  a_id_data_keep: assert property (wr_i && sel_data && flag_reg[ST_ID_BIT]
                                   |=> flag_reg[ST_ID_BIT])
    else $error("data write cleared identifier flag");

  // interrupts
  a_err_irq_level: assert property (err_reg != 8'h00 && ien_reg[EN_ERR_BIT]
                                    |-> irq_err_o)
    else $error("error irq dropped");
  a_ok_irq_masked: assert property (ien_reg[2:0] == 3'h0 |-> !irq_ok_o)
    else $error("ok irq while masked");
  a_ok_irq_quiet: assert property (flag_reg == 3'h0 |-> !irq_ok_o)
    else $error("ok irq without flag");

  // command decode
  a_rx_hdr_cmd: assert property (ctl_ena && !uart_mode && code == 3'b000
                                 |=> cmd_o.rx_header)
    else $error("rx header not decoded");
  a_tx_hdr_cmd: assert property (ctl_ena && !uart_mode && code == 3'b001
                                 |=> cmd_o.tx_header)
    else $error("tx header not decoded");
  a_rx_rsp_cmd: assert property (ctl_ena && code == 3'b010
                                 |=> cmd_o.rx_response)
    else $error("rx response not decoded");
  a_tx_rsp_cmd: assert property (ctl_ena && code == 3'b011
                                 |=> cmd_o.tx_response)
    else $error("tx response not decoded");
  a_uart_off_cmd: assert property (ctl_ena && uart_mode && code == 3'b100
                                   |=> cmd_o.uart_off)
    else $error("uart disable not decoded");
  a_uart_rx_cmd: assert property (ctl_ena && uart_mode && code[1]
                                  |=> cmd_o.uart_rx_en)
    else $error("uart rx enable not decoded");
  a_uart_tx_cmd: assert property (ctl_ena && uart_mode && code[0]
                                  |=> cmd_o.uart_tx_en)
    else $error("uart tx enable not decoded");

endmodule

// File: tb/lsf_engine.sv
// Purpose: frame engine stand-in that raises event and error pulses
// Assumes: one job at a time, started by a one-cycle go_i, gap_i of 1 or more
// Notes:   ident toggles outside its pulse so a stale latch cannot pass
`timescale 1ns/1ps
module lsf_engine
  import lsf_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] kind_i,
  input  wire logic [5:0] id_i,
  input  wire logic [7:0] gap_i,
  output lsf_evt_s        evt_o,
  output lsf_err_s        err_o
);
  logic [7:0] cnt_reg = 8'h00;
  logic [2:0] kind_reg = 3'h0;
  logic [5:0] id_reg = 6'h00;
  lsf_evt_s   evt_nxt;
  lsf_err_s   err_nxt;
  initial begin
    evt_o = '0;
    err_o = '0;
  end
  // next values built first so each output is assigned once per edge
  always @(posedge clk_i) begin
    evt_nxt = '0;
    evt_nxt.ident = ~evt_o.ident;
    err_nxt = '0;
    if (go_i) begin
      cnt_reg <= gap_i;
      kind_reg <= kind_i;
      id_reg <= id_i;
      evt_nxt.busy = 1'b1;
    end else if (cnt_reg > 8'h01) begin
      cnt_reg <= cnt_reg - 8'h01;
      evt_nxt.busy = 1'b1;
    end else if (cnt_reg == 8'h01) begin
      cnt_reg <= 8'h00;
      evt_nxt.ident = id_reg;
      evt_nxt.id_rcvd = (kind_reg == 3'h0);
      evt_nxt.hdr_tx_done = (kind_reg == 3'h1);
      evt_nxt.rsp_tx_done = (kind_reg == 3'h2);
      evt_nxt.rsp_rx_done = (kind_reg == 3'h3);
      if (kind_reg[2]) begin
        err_nxt = lsf_err_s'(8'h01 << id_reg[2:0]);
      end
    end
    evt_o <= evt_nxt;
    err_o <= err_nxt;
  end
endmodule

// File: tb/tb_lsf_flags.sv
// Purpose: self-checking bench for the status and flag bank
// Assumes: engine model supplies events, bench drives the register port
// Notes:   flags given two edges to settle after their cause
`timescale 1ns/1ps
module tb_lsf_flags;
  logic       clk_i, rst_i, wr_i, rd_i, go, irq_err, irq_ok;
  logic [7:0] addr, wdata, rdata, gap, v;
  logic [2:0] kind;
  logic [5:0] idv;
  lsf_pkg::lsf_evt_s evt;
  lsf_pkg::lsf_err_s err;
  lsf_pkg::lsf_cmd_s cmd;
  int         comparisons = 0;
  int         miscompares = 0;
  logic [7:0] cexp [8] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h02, 8'h03};
  lsf_flags dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata), .evt_i(evt), .err_i(err), .cmd_o(cmd),
    .irq_err_o(irq_err), .irq_ok_o(irq_ok));
  lsf_engine eng (.clk_i(clk_i), .go_i(go), .kind_i(kind), .id_i(idv), .gap_i(gap),
    .evt_o(evt), .err_o(err));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic job(input logic [2:0] k, input logic [5:0] i);
    @(posedge clk_i);
    go <= 1'b1;
    kind <= k;
    idv <= i;
    gap <= 8'h06;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    rd(8'hc9, v);
    chk(v & 8'h10, 8'h10);
    repeat (6) @(posedge clk_i);
  endtask
  task automatic t_reset;
    foreach (cexp[i]) if (i < 4) begin
      rd(8'hc8 + 8'(i), v);
      chk(v, 8'h00);
    end
    rd(8'he0, v);
    chk(v, 8'h00);
    wr(8'hca, 8'hff);
    rd(8'hca, v);
    chk(v, 8'h0f);
    wr(8'hcb, 8'hff);
    rd(8'hcb, v);
    chk(v, 8'h00);
    wr(8'hca, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_events;
    job(3'h0, 6'h3c);
    rd(8'hc9, v);
    chk(v, 8'h84);
    job(3'h1, 6'h3f);
    rd(8'hc9, v);
    chk(v, 8'he4);
    job(3'h0, 6'h05);
    job(3'h2, 6'h00);
    job(3'h3, 6'h00);
    rd(8'hc9, v);
    chk(v & 8'h9f, 8'h07);
    wr(8'hc9, 8'h00);
    rd(8'hc9, v);
    chk(v & 8'h1f, 8'h07);
    wr(8'hc9, 8'h04);
    rd(8'hc9, v);
    chk(v & 8'h1f, 8'h03);
    wr(8'hc9, 8'h03);
    rd(8'hc9, v);
    chk(v & 8'h1f, 8'h00);
    $display("test events done");
  endtask
  task automatic t_irq;
    job(3'h3, 6'h00);
    settle();
    chk({7'h0, irq_ok}, 8'h00);
    wr(8'hca, 8'h01);
    settle();
    chk({7'h0, irq_ok}, 8'h01);
    wr(8'hca, 8'h06);
    job(3'h2, 6'h00);
    repeat (5) begin
      settle();
      chk({7'h0, irq_ok}, 8'h01);
    end
    wr(8'hc9, 8'h03);
    settle();
    chk({7'h0, irq_ok}, 8'h00);
    $display("test irq done");
  endtask
  task automatic t_err;
    wr(8'hca, 8'h08);
    for (int i = 0; i < 8; i++) begin
      job(3'h4, 6'(i));
      rd(8'hcb, v);
      chk(v, 8'h01 << i);
      rd(8'hc9, v);
      chk(v & 8'h08, 8'h08);
      chk({7'h0, irq_err}, 8'h01);
      wr(8'hc9, 8'h08);
      rd(8'hcb, v);
      chk(v, 8'h00);
      settle();
      chk({7'h0, irq_err}, 8'h00);
    end
    wr(8'hca, 8'h00);
    job(3'h4, 6'h03);
    settle();
    chk({7'h0, irq_err}, 8'h00);
    wr(8'hc9, 8'h08);
    $display("test errors done");
  endtask
  task automatic t_cmd;
    wr(8'hc8, 8'h09);
    wr(8'hc8, 8'h08);
    settle();
    chk({1'b0, cmd}, cexp[0]);
    rd(8'hcb, v);
    chk(v, 8'h80);
    wr(8'hc9, 8'h08);
    for (int i = 1; i < 8; i++) begin
      wr(8'hc8, 8'h08 | 8'(i));
      settle();
      chk({1'b0, cmd}, cexp[i]);
    end
    wr(8'hc8, 8'h00);
    settle();
    chk({1'b0, cmd}, 8'h00);
    rd(8'hcb, v);
    chk(v, 8'h00);
    $display("test commands done");
  endtask
  task automatic t_uart;
    wr(8'hc8, 8'h0f);
    job(3'h2, 6'h00);
    job(3'h3, 6'h00);
    job(3'h4, 6'h05);
    wr(8'hd2, 8'h5a);
    rd(8'hc9, v);
    chk(v & 8'h0b, 8'h08);
    rd(8'hd2, v);
    rd(8'hc9, v);
    chk(v & 8'h0b, 8'h00);
    rd(8'hcb, v);
    chk(v, 8'h00);
    wr(8'hc8, 8'h0a);
    job(3'h3, 6'h00);
    wr(8'hd2, 8'h33);
    rd(8'hc9, v);
    chk(v & 8'h03, 8'h01);
    $display("test uart done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst_i, wr_i, rd_i, go} = 4'b1000;
    {addr, wdata, gap, kind, idv} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_events();
    t_irq();
    t_err();
    t_cmd();
    t_uart();
    stop_test();
  end
endmodule
